// ---- pcicsc_defines.vh ----
`ifndef PCICSC_DEFINES_VH
`define PCICSC_DEFINES_VH
`define PCICSC_ADDR_W        8
`define PCICSC_ADDR_STATCMD  8'h04
`define PCICSC_ADDR_CLASS    8'h08
`define PCICSC_MODE_W        3
`define PCICSC_MODE_ZERO     3'h0
`define PCICSC_MODE_PCI      3'h1
`define PCICSC_LANE_CMD      0
`define PCICSC_LANE_CMD_HI   1
`define PCICSC_LANE_STAT_HI  3
`define PCICSC_BIT_MEM_EN    1
`define PCICSC_BIT_MASTER_EN 2
`define PCICSC_BIT_PAR_RESP  6
`define PCICSC_BIT_SYSERR_EN 8
`define PCICSC_BIT_FAST_B2B  23
`define PCICSC_BIT_PAR_RPT   24
`define PCICSC_DEVSEL_LO     25
`define PCICSC_DEVSEL_HI     26
`define PCICSC_BIT_SIG_TABT  27
`define PCICSC_BIT_RCV_TABT  28
`define PCICSC_BIT_RCV_MABT  29
`define PCICSC_BIT_SIG_SYSE  30
`define PCICSC_BIT_PAR_DET   31
`define PCICSC_DEVSEL_MEDIUM 2'h1
`define PCICSC_ZERO32        32'h0000_0000
`define PCICSC_DEF_CLASS     32'h0000_0000
`endif

// ---- pcicsc_w1c_flag.v ----
module pcicsc_w1c_flag (
  input  wire clk_sys,
  input  wire rstn,
  input  wire set_i,
  input  wire clr_i,
  output reg  flag_q
);
  // set beats a clear in the same cycle
  always @(posedge clk_sys) begin
    if (!rstn)
      flag_q <= 1'b0;
    else if (set_i)
      flag_q <= 1'b1;
    else if (clr_i)
      flag_q <= 1'b0;
  end
endmodule

// ---- pcicsc_pulse_pin.v ----
module pcicsc_pulse_pin (
  input  wire clk_sys,
  input  wire rstn,
  input  wire allow_i,
  input  wire fire_i,
  output reg  pin_n_q,
  output reg  pin_oe_q
);
  // active-low pin, one-cycle pulse; enable dropped while not allowed
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pin_n_q  <= 1'b1;
      pin_oe_q <= 1'b0;
    end else begin
      pin_n_q  <= ~(allow_i & fire_i);
      pin_oe_q <= allow_i & fire_i;
    end
  end
endmodule

// ---- pcicsc_config_regs.v ----
// Summary of operation
// - in pci mode, memory accesses answered only while memory space enable is set.
// - reset clears all writable command bits and all sticky status flags.
// - no bus-master transaction starts while master enable is clear.
// - master enable clear forces the processor-side master request flag low.
// - parity pin driven only with parity response on; pulses on parity error.
// - parity response on: data parity error as master or parity pin low sets parity reported.
// - parity error sets detected flag, processor flag, irq if enabled.
// - wait cycle control bit reads zero, writes ignored.
// - system error enable clear keeps system-error pin undriven.
// - system error pulse on forced error while active or address parity error.
// - fast back-to-back capable bit reads constant one.
// - parity response on: data parity error as master, or pin sampled low in either role, sets parity reported.
// - sticky flags clear only by host writing one; zero leaves them.
// - devsel timing field reads constant medium value one.
// - target-abort as target sets signalled target abort.
// - master transaction ended by target-abort sets received target abort.
// - master-abort of own transaction sets received master abort.
// - each system-error pin assertion sets signalled system error.
// - any address or data parity error sets detected parity error.
// - reserved and unimplemented bits read as zero.
// - class code register read-only, reachable only in pci mode.
// - class code fields fixed: revision, interface, sub-class, base class; reset-proof.
// - host writes update only enabled byte lanes.
// - status/command selected at its address in pci mode or mode zero.
`include "pcicsc_defines.vh"
module pcicsc_config_regs #(
  parameter [31:0] CLASS_REV = `PCICSC_DEF_CLASS  // arbitrary value
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire [2:0]  host_mode_field,
  input  wire        cfg_rd,
  input  wire        cfg_wr,
  input  wire [7:0]  cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  input  wire        mem_access_req,
  input  wire        master_start_req,
  input  wire        master_request_flag_set,
  input  wire        master_request_flag_clr,
  input  wire        data_parity_err,
  input  wire        addr_parity_err,
  input  wire        acting_master,
  input  wire        parity_error_pin_in,
  input  wire        target_abort_sent,
  input  wire        target_abort_rcvd,
  input  wire        master_abort_done,
  input  wire        force_sys_error,
  input  wire        agent_active,
  input  wire        parity_irq_enable,
  input  wire        proc_parity_error_clr,
  output reg  [31:0] cfg_rdata,
  output reg         cfg_rvalid,
  output reg         mem_access_ack,
  output reg         master_start_ok,
  output reg         master_request_flag,
  output reg         proc_parity_error_flag,
  output reg         parity_irq,
  output wire        parity_error_pin_out,
  output wire        parity_error_pin_oe,
  output wire        sys_error_pin_out,
  output wire        sys_error_pin_oe
);
  wire pci_mode = (host_mode_field == `PCICSC_MODE_PCI);
  wire sc_sel   = (cfg_addr == `PCICSC_ADDR_STATCMD) &&
                  (pci_mode || host_mode_field == `PCICSC_MODE_ZERO);
  wire wr_sc    = cfg_wr && sc_sel;

  reg mem_space_enable_q;
  reg master_enable_q;
  reg parity_response_enable_q;
  reg sys_error_enable_q;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      mem_space_enable_q       <= 1'b0;
      master_enable_q          <= 1'b0;
      parity_response_enable_q <= 1'b0;
      sys_error_enable_q       <= 1'b0;
    end else if (wr_sc) begin
      // byte-lane gated; wcc and unimplemented bits have no storage
      if (cfg_be[`PCICSC_LANE_CMD]) begin
        mem_space_enable_q       <= cfg_wdata[`PCICSC_BIT_MEM_EN];
        master_enable_q          <= cfg_wdata[`PCICSC_BIT_MASTER_EN];
        parity_response_enable_q <= cfg_wdata[`PCICSC_BIT_PAR_RESP];
      end
      if (cfg_be[`PCICSC_LANE_CMD_HI])
        sys_error_enable_q <= cfg_wdata[`PCICSC_BIT_SYSERR_EN];
    end
  end

  // event qualification
  wire any_parity   = pci_mode && (data_parity_err || addr_parity_err);
  wire par_pin_fire = pci_mode && parity_response_enable_q && any_parity;
  wire par_rpt_set  = pci_mode && parity_response_enable_q &&
                      ((acting_master && data_parity_err) ||
                       !parity_error_pin_in);
  wire sys_pin_fire = pci_mode && sys_error_enable_q &&
                      ((force_sys_error && agent_active) || addr_parity_err);
  wire sig_tabt_set = pci_mode && target_abort_sent;
  wire rcv_tabt_set = pci_mode && acting_master && target_abort_rcvd;
  wire rcv_mabt_set = pci_mode && acting_master && master_abort_done;

  wire lane3 = wr_sc && cfg_be[`PCICSC_LANE_STAT_HI];
  wire par_rpt_q, sig_tabt_q, rcv_tabt_q, rcv_mabt_q, sig_syse_q, par_det_q;

  // sticky flags: only a written one clears
  pcicsc_w1c_flag u_par_rpt (.clk_sys(clk_sys), .rstn(rstn), .set_i(par_rpt_set),
    .clr_i(lane3 && cfg_wdata[`PCICSC_BIT_PAR_RPT]), .flag_q(par_rpt_q));
  pcicsc_w1c_flag u_sig_tabt (.clk_sys(clk_sys), .rstn(rstn), .set_i(sig_tabt_set),
    .clr_i(lane3 && cfg_wdata[`PCICSC_BIT_SIG_TABT]), .flag_q(sig_tabt_q));
  pcicsc_w1c_flag u_rcv_tabt (.clk_sys(clk_sys), .rstn(rstn), .set_i(rcv_tabt_set),
    .clr_i(lane3 && cfg_wdata[`PCICSC_BIT_RCV_TABT]), .flag_q(rcv_tabt_q));
  pcicsc_w1c_flag u_rcv_mabt (.clk_sys(clk_sys), .rstn(rstn), .set_i(rcv_mabt_set),
    .clr_i(lane3 && cfg_wdata[`PCICSC_BIT_RCV_MABT]), .flag_q(rcv_mabt_q));
  pcicsc_w1c_flag u_sig_syse (.clk_sys(clk_sys), .rstn(rstn), .set_i(sys_pin_fire),
    .clr_i(lane3 && cfg_wdata[`PCICSC_BIT_SIG_SYSE]), .flag_q(sig_syse_q));
  pcicsc_w1c_flag u_par_det (.clk_sys(clk_sys), .rstn(rstn), .set_i(any_parity),
    .clr_i(lane3 && cfg_wdata[`PCICSC_BIT_PAR_DET]), .flag_q(par_det_q));

  // pins: enable low keeps them off the wire
  pcicsc_pulse_pin u_par_pin (.clk_sys(clk_sys), .rstn(rstn),
    .allow_i(parity_response_enable_q), .fire_i(par_pin_fire),
    .pin_n_q(parity_error_pin_out), .pin_oe_q(parity_error_pin_oe));
  pcicsc_pulse_pin u_sys_pin (.clk_sys(clk_sys), .rstn(rstn),
    .allow_i(sys_error_enable_q), .fire_i(sys_pin_fire),
    .pin_n_q(sys_error_pin_out), .pin_oe_q(sys_error_pin_oe));

  reg [31:0] sc_word;
  always @* begin
    sc_word = `PCICSC_ZERO32;
    sc_word[`PCICSC_BIT_MEM_EN]    = mem_space_enable_q;
    sc_word[`PCICSC_BIT_MASTER_EN] = master_enable_q;
    sc_word[`PCICSC_BIT_PAR_RESP]  = parity_response_enable_q;
    sc_word[`PCICSC_BIT_SYSERR_EN] = sys_error_enable_q;
    sc_word[`PCICSC_BIT_FAST_B2B]  = 1'b1;
    sc_word[`PCICSC_BIT_PAR_RPT]   = par_rpt_q;
    sc_word[`PCICSC_DEVSEL_HI:`PCICSC_DEVSEL_LO] = `PCICSC_DEVSEL_MEDIUM;
    sc_word[`PCICSC_BIT_SIG_TABT]  = sig_tabt_q;
    sc_word[`PCICSC_BIT_RCV_TABT]  = rcv_tabt_q;
    sc_word[`PCICSC_BIT_RCV_MABT]  = rcv_mabt_q;
    sc_word[`PCICSC_BIT_SIG_SYSE]  = sig_syse_q;
    sc_word[`PCICSC_BIT_PAR_DET]   = par_det_q;
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      cfg_rdata  <= `PCICSC_ZERO32;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd && sc_sel)
        cfg_rdata <= sc_word;
      else if (cfg_rd && pci_mode && cfg_addr == `PCICSC_ADDR_CLASS)
        cfg_rdata <= CLASS_REV;
      else
        cfg_rdata <= `PCICSC_ZERO32;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      mem_access_ack         <= 1'b0;
      master_start_ok        <= 1'b0;
      master_request_flag    <= 1'b0;
      proc_parity_error_flag <= 1'b0;
      parity_irq             <= 1'b0;
    end else begin
      mem_access_ack  <= pci_mode && mem_space_enable_q && mem_access_req;
      master_start_ok <= pci_mode && master_enable_q && master_start_req;
      // forced low whenever master enable is clear
      if (!master_enable_q)
        master_request_flag <= 1'b0;
      else if (master_request_flag_set)
        master_request_flag <= 1'b1;
      else if (master_request_flag_clr)
        master_request_flag <= 1'b0;
      if (any_parity)
        proc_parity_error_flag <= 1'b1;
      else if (proc_parity_error_clr)
        proc_parity_error_flag <= 1'b0;
      parity_irq <= any_parity && parity_irq_enable;
    end
  end
endmodule

// ---- pcicsc_assertions.sv ----
module pcicsc_checker #(
  parameter [31:0] CLASS_REV = 32'h0000_0000
) (
  input wire        clk_sys,
  input wire        rstn,
  input wire [2:0]  host_mode_field,
  input wire        cfg_rd,
  input wire [7:0]  cfg_addr,
  input wire        mem_access_req,
  input wire        master_start_req,
  input wire        data_parity_err,
  input wire        addr_parity_err,
  input wire        parity_irq_enable,
  input wire [31:0] cfg_rdata,
  input wire        cfg_rvalid,
  input wire        mem_access_ack,
  input wire        master_start_ok,
  input wire        parity_irq,
  input wire        parity_error_pin_out,
  input wire        parity_error_pin_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  AST_MEM_ACK: assert property (mem_access_ack |-> $past(mem_access_req) &&
    $past(host_mode_field) == 3'h1) else $error("ack without pci request");
  AST_MASTER_OK: assert property (master_start_ok |-> $past(master_start_req) &&
    $past(host_mode_field) == 3'h1) else $error("master start without request");
  AST_PARPIN_DRIVE: assert property (!parity_error_pin_out |-> parity_error_pin_oe)
    else $error("parity pin low while undriven");
  AST_PARPIN_CAUSE: assert property (parity_error_pin_oe |-> $past(data_parity_err) ||
    $past(addr_parity_err)) else $error("parity pin driven without error");
  AST_IRQ_CAUSE: assert property (parity_irq |-> $past(parity_irq_enable) &&
    ($past(data_parity_err) || $past(addr_parity_err))) else $error("irq without cause");
  AST_RVALID: assert property (cfg_rvalid |-> $past(cfg_rd))
    else $error("read answer without read");
  AST_CLASS_RD: assert property ($past(cfg_rd) && $past(cfg_addr) == 8'h08 &&
    $past(host_mode_field) == 3'h1 |-> cfg_rvalid && cfg_rdata == CLASS_REV)
    else $error("class read wrong");
  AST_STAT_RD: assert property ($past(cfg_rd) && $past(cfg_addr) == 8'h04 &&
    $past(host_mode_field) == 3'h1 |-> {cfg_rdata[26:25], cfg_rdata[23]} == 3'b011 &&
    (cfg_rdata & 32'h007f_feb9) == 32'h0) else $error("status constant bits wrong");
endmodule
bind pcicsc_config_regs pcicsc_checker #(.CLASS_REV(CLASS_REV)) u_pcicsc_checker (.*);

// ---- pcicsc_host_model.sv ----
module pcicsc_host_model (
  input  wire         clk_sys,
  input  wire  [31:0] cfg_rdata,
  input  wire         cfg_rvalid,
  output logic        cfg_rd = 1'b0,
  output logic        cfg_wr = 1'b0,
  output logic [7:0]  cfg_addr = 8'h00,
  output logic [3:0]  cfg_be = 4'h0,
  output logic [31:0] cfg_wdata = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // released address and data lines show inverted values so a stale address never looks valid
  task automatic cfg(input bit w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d, output logic [31:0] q, output bit to);
    int n = 0;
    @(posedge clk_sys);
    {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {!w, w, a, b, d};
    @(posedge clk_sys);
    {cfg_rd, cfg_wr, cfg_addr, cfg_wdata} <= {2'b00, ~a, ~d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (!w && cfg_rvalid !== 1'b1 && n < 4);
    q = cfg_rdata;
    to = !w && cfg_rvalid !== 1'b1;
  endtask
endmodule

// ---- pcicsc_config_regs_test.sv ----
module pcicsc_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] CLS = 32'h5a3c_0102;  // arbitrary value
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  host_mode_field = 3'h1;
  logic [9:0]  ev = 10'h000;
  logic [31:0] q;
  logic [6:0]  seen;
  logic        acting_master = 1'b1;
  logic        agent_active = 1'b1;
  bit          to;
  int          err_total = 0;
  int          checks = 0;
  // tied: processor-side clears stay out of reach here
  wire master_request_flag_clr = 1'b0, proc_parity_error_clr = 1'b0;
  wire cfg_rd, cfg_wr, cfg_rvalid, mem_access_ack, master_start_ok, master_request_flag;
  wire proc_parity_error_flag, parity_irq, parity_error_pin_out, parity_error_pin_oe;
  wire sys_error_pin_out, sys_error_pin_oe, mem_access_req, master_start_req;
  wire master_request_flag_set, data_parity_err, addr_parity_err, target_abort_sent;
  wire target_abort_rcvd, master_abort_done, force_sys_error, parity_irq_enable;
  wire [7:0]  cfg_addr;
  wire [3:0]  cfg_be;
  wire [31:0] cfg_wdata, cfg_rdata;
  // pulled-up wire: high whenever nobody drives it
  wire parity_error_pin_in = parity_error_pin_oe ? parity_error_pin_out : 1'b1;
  assign {parity_irq_enable, force_sys_error, master_abort_done, target_abort_rcvd,
          target_abort_sent, addr_parity_err, data_parity_err, master_request_flag_set,
          master_start_req, mem_access_req} = ev;
  pcicsc_config_regs #(.CLASS_REV(CLS)) u_pcicsc_config_regs (.*);
  pcicsc_host_model u_pcicsc_host_model (.*);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    u_pcicsc_host_model.cfg(1'b0, a, 4'h0, 32'h0, q, to);
    chk(nm, e, q);
    err_total += to;
    if (to) wrap_up;
  endtask
  task wr(input logic [3:0] b, input logic [31:0] d);
    u_pcicsc_host_model.cfg(1'b1, 8'h04, b, d, q, to);
  endtask
  task fire(input logic [9:0] m);
    @(posedge clk_sys) ev <= m;
    @(posedge clk_sys) ev <= 10'h000;
    #1;
    seen = {mem_access_ack, master_start_ok, parity_error_pin_oe, sys_error_pin_oe, parity_irq,
            parity_error_pin_out, sys_error_pin_out};
  endtask
  task s_cmd;
    wr(4'hf, 32'hff00_01c6);
    rd(8'h04, 32'h0280_0146, "cmd_all");
    wr(4'h2, 32'h0);
    rd(8'h04, 32'h0280_0046, "cmd_lane");
    wr(4'h2, 32'h0000_0100);
    fire(10'h007);
    chk("ack_ok", 7'b1100011, seen);
    chk("mreq", 1'b1, master_request_flag);
  endtask
  task s_flags;
    fire(10'h3f8);
    chk("pins", 7'b0011100, seen);
    chk("proc_flag", 1'b1, proc_parity_error_flag);
    rd(8'h04, 32'hfb80_0146, "flags");
    wr(4'hf, 32'h0000_0146);
    rd(8'h04, 32'hfb80_0146, "zero_kept");
    wr(4'h8, 32'h0800_0000);
    rd(8'h04, 32'hf380_0146, "clr_one");
    wr(4'h8, 32'hf300_0000);
    rd(8'h04, 32'h0280_0146, "clr_all");
  endtask
  task s_role;
    @(posedge clk_sys) {acting_master, agent_active} <= 2'b00;
    fire(10'h1e0);
    chk("role_pins", 7'b0000011, seen);
    rd(8'h04, 32'h0a80_0146, "role_flags");
    wr(4'h8, 32'h0800_0000);
    @(posedge clk_sys) {acting_master, agent_active} <= 2'b11;
  endtask
  task s_off;
    wr(4'hf, 32'h0);
    fire(10'h01f);
    chk("off", 7'b0000011, seen);
    chk("mreq_off", 1'b0, master_request_flag);
    rd(8'h04, 32'h8280_0000, "dpe_only");
  endtask
  task s_mode;
    @(posedge clk_sys) host_mode_field <= 3'h2;
    rd(8'h04, 32'h0, "mode2");
    @(posedge clk_sys) host_mode_field <= 3'h0;
    rd(8'h04, 32'h8280_0000, "mode0");
    rd(8'h08, 32'h0, "class_m0");
    @(posedge clk_sys) host_mode_field <= 3'h1;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h04, 32'h0280_0000, "stat_rst");
    rd(8'h08, CLS, "class");
    rd(8'h0c, 32'h0, "unmapped");
    s_cmd;
    s_flags;
    s_role;
    s_off;
    s_mode;
    wr(4'h1, 32'h0000_0006);
    @(posedge clk_sys) rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(8'h04, 32'h0280_0000, "stat_rst2");
    rd(8'h08, CLS, "class_rst2");
    wrap_up;
  end
endmodule
